/* File: eight_bit_gpio_port_analog_mux_tb_top.sv */
// self-checking bench for the eight-bit port
`timescale 1ns/1ps
module eight_bit_gpio_port_analog_mux_tb_top;
  // clock, reset, bus and comparators
  logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, cmpA, cmpB;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  // pins and side controls
  logic [7:0]  pinIn, pinOut, pinOe, extLevel, extDrive;
  logic [6:0]  analogEnable;
  logic        refOutEnable, slaveSelect;
  // bench state
  logic [7:0]  dir, lat, cfg;
  logic [15:0] rnd;
  int          errTotal, cmpCount;

  // the one slave's ready is the bus ready
  gpf_port i_dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .pinIn, .pinOut, .pinOe, .firstComparatorResult(cmpA),
    .secondComparatorResult(cmpB), .analogEnable, .refOutEnable, .slaveSelect);
  gpf_pin_model i_board (.pinOut, .pinOe, .extLevel, .extDrive, .pinIn);

  // free-running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // next random word
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // pins held analog by a converter setting
  function automatic logic [7:0] anaMask(input logic [7:0] c);
    anaMask = 8'h00;
    for (int i = 0; i < 7; i++)
      anaMask[i] = (c[3:0] <= 9 - i);
  endfunction : anaMask

  // compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // verdict and end of run
  task automatic endSim();
    if (errTotal == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : endSim

  // one bus phase; a stall past the bound ends the run
  task automatic waitRdy();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      errTotal++;
      endSim();
    end
  endtask : waitRdy

  // single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    waitRdy();
  endtask : bus

  // read and compare the low byte
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, hrdata[7:0], exp);
  endtask : rdChk

  initial
  begin
    {hsel, hwrite, cmpA, cmpB, htrans, haddr, hwdata, extLevel, extDrive} = '0;
    hsize = 3'h2;
    rst = 1'b1;
    errTotal = 0;
    cmpCount = 0;
    rnd = 16'h5C53;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("ana", {1'b0, analogEnable}, 8'h7F);
    // pins 0..6 read zero, pin 7 pulled up
    for (int i = 0; i < 6; i++)
      rdChk("rst", 8'(4 * i), i == 0 ? 8'hFF : (i == 1 ? 8'h80 : 8'h00));
    bus(1'b1, gpf_pkg::OFS_ADC, 8'hFF);
    rdChk("adc", gpf_pkg::OFS_ADC, 8'h3F);
    bus(1'b1, 8'h18, 8'h5A);
    rdChk("gap", 8'h18, 8'h00);
    bus(1'b1, gpf_pkg::OFS_CMP, 8'h07);
    bus(1'b1, gpf_pkg::OFS_ADC, 8'h0F);
    // random direction, latch, levels and converter setting
    for (int k = 0; k < 24; k++)
    begin
      rnd = lfsr(rnd);
      dir = rnd[7:0];
      lat = rnd[15:8];
      rnd = lfsr(rnd);
      cfg = {4'h0, rnd[3:0]};
      extDrive <= extDrive & dir;
      extLevel <= rnd[15:8];
      bus(1'b1, gpf_pkg::OFS_ADC, cfg);
      bus(1'b1, k[0] ? gpf_pkg::OFS_PIN : gpf_pkg::OFS_LAT, lat);
      bus(1'b1, gpf_pkg::OFS_DIR, dir);
      // board takes over new inputs only once the device has let go of them
      @(posedge ref_clk);
      extDrive <= dir;
      // two sync stages plus the registered select need the extra edges
      repeat (5) @(posedge ref_clk);
      chk("oe", pinOe, ~dir);
      chk("out", pinOut & ~dir, lat & ~dir);
      chk("ana", {1'b0, analogEnable}, anaMask(cfg));
      chk("sel", {7'h0, slaveSelect}, {7'h0, dir[7] ? extLevel[7] : 1'b1});
      rdChk("lat", gpf_pkg::OFS_LAT, lat);
      rdChk("pin", gpf_pkg::OFS_PIN, ((dir & extLevel) | (~dir & lat)) & ~anaMask(cfg));
    end
    // comparator results drive pins 1 and 2
    extDrive <= 8'h00;
    bus(1'b1, gpf_pkg::OFS_ADC, 8'h0F);
    bus(1'b1, gpf_pkg::OFS_DIR, 8'hF9);
    bus(1'b1, gpf_pkg::OFS_CMP, {5'h00, gpf_pkg::CMP_MODE_OUTS});
    for (int m = 0; m < 4; m++)
    begin
      cmpA <= m[0];
      cmpB <= m[1];
      repeat (5) @(posedge ref_clk);
      chk("cmpOut", {6'h0, pinOut[2:1]}, {6'h0, m[0], m[1]});
      rdChk("cmpReg", gpf_pkg::OFS_CMP, {m[1], m[0], 6'h03});
    end
    rdChk("cmpPin", gpf_pkg::OFS_PIN, 8'h87);
    // reference output on pin 5 with pins 0 to 6 analog
    bus(1'b1, gpf_pkg::OFS_CMP, 8'h07);
    bus(1'b1, gpf_pkg::OFS_ADC, 8'h00);
    bus(1'b1, gpf_pkg::OFS_DIR, 8'h00);
    bus(1'b1, gpf_pkg::OFS_LAT, 8'hFF);
    bus(1'b1, gpf_pkg::OFS_REF, 8'hC0);
    repeat (4) @(posedge ref_clk);
    chk("refOe", {6'h0, refOutEnable, pinOe[5]}, 8'h02);
    chk("anaOut", pinOut & 8'hDF, 8'hDF);
    rdChk("refPin", gpf_pkg::OFS_PIN, 8'h80);
    rdChk("ref", gpf_pkg::OFS_REF, 8'hC0);
    endSim();
  end
endmodule : eight_bit_gpio_port_analog_mux_tb_top

// checker on the port's own pins
bind gpf_port gpf_port_sva i_sva (.ref_clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
  .hresp, .pinIn, .pinOut, .pinOe, .analogEnable, .refOutEnable, .slaveSelect);

/* File: gpf_pin_model.sv */
// board model: resolves each pin from device drive, board drive and pull-ups
`timescale 1ns/1ps
module gpf_pin_model (
  // device side
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  // board drivers
  input  wire logic [7:0] extLevel,
  input  wire logic [7:0] extDrive,
  // level seen at the pins
  output logic      [7:0] pinIn
);
  // wire level
  // an undriven pin is pulled up; the bench never lets both sides drive
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive & extLevel) | ~(pinOe | extDrive);
endmodule : gpf_pin_model

/* File: gpf_pkg.sv */
// constants shared by the eight-bit port with analog and comparator sharing
package gpf_pkg;

  // register byte offsets on the bus (one aligned word each)
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_PIN = 8'h04;
  localparam logic [7:0] OFS_LAT = 8'h08;
  localparam logic [7:0] OFS_ADC = 8'h0C;
  localparam logic [7:0] OFS_CMP = 8'h10;
  localparam logic [7:0] OFS_REF = 8'h14;

  // reset values
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] ADC_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'h00;

  // writable masks: top two converter bits unimplemented
  localparam logic [7:0] ADC_WMASK = 8'h3F;
  // comparator result bits 7:6 are read-only
  localparam logic [7:0] CMP_WMASK = 8'h3F;

  // field positions
  localparam int CMP_MODE_LSB   = 0;
  localparam int CMP_RES1_BIT   = 6;
  localparam int CMP_RES2_BIT   = 7;
  localparam int REF_EN_BIT     = 7;
  localparam int REF_OE_BIT     = 6;
  localparam int PCFG_LSB       = 0;

  // comparator mode encodings
  localparam logic [2:0] CMP_MODE_OFF  = 3'h7;
  localparam logic [2:0] CMP_MODE_OUTS = 3'h3;

  // converter channel of pin 0; a pin is analog while
  // port_config_field <= PCFG_ALL_ANALOG_TOP - channel
  localparam logic [4:0] FIRST_CHANNEL      = 5'h05;
  localparam logic [4:0] PCFG_ALL_ANALOG_TOP = 5'h0E;

  // special pins
  localparam int PIN_CMP2_OUT = 1;
  localparam int PIN_CMP1_OUT = 2;
  localparam int PIN_CMP_INLO = 3;
  localparam int PIN_CMP_INHI = 6;
  localparam int PIN_REF_OUT  = 5;
  localparam int PIN_SEL_IN   = 7;
  localparam int ANALOG_PINS  = 7;

  // htrans encoding bit for active transfers
  localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : gpf_pkg

/* File: gpf_port.sv */
// eight-bit general-purpose port with analog, comparator and select sharing
`timescale 1ns/1ps

module gpf_port #(
  parameter int PIN_COUNT = 8  // the port is exactly eight pins wide
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // port pins
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOe,
  // comparator results from the analog side
  input  wire logic        firstComparatorResult,
  input  wire logic        secondComparatorResult,
  // controls to the analog side and serial module
  output logic      [6:0]  analogEnable,
  output logic             refOutEnable,
  output logic             slaveSelect
);

  // the fixed pin roles below assume eight pins
  if (PIN_COUNT != 8)
  begin : g_width_check
    $error("gpf_port supports exactly eight pins");
  end

  // software-visible registers
  logic [7:0] fDirection_q, fDirection_d;   // one = input
  logic [7:0] fLatch_q, fLatch_d;           // output latch
  logic [7:0] convCfg_q, convCfg_d;         // converter config
  logic [7:0] cmpCtrl_q, cmpCtrl_d;         // comparator control
  logic [7:0] refCtrl_q, refCtrl_d;         // reference control

  // bus data-phase bookkeeping
  logic       wrPend_q;                     // write awaiting data
  logic [7:0] wrAddr_q;                     // its byte offset
  logic       accept;                       // address phase taken

  // pin and comparator synchronisers
  logic [7:0] pinMeta_q, pinSync_q;
  logic [1:0] cmpMeta_q, cmpSync_q;

  // derived per-pin controls
  logic [7:0] analogOn;                     // analog input enabled
  logic [7:0] digInOk;                      // digital read allowed
  logic [7:0] pinRead;                      // value seen by software
  logic [7:0] oeNext, outNext;              // next pin drive
  logic       cmpActive;                    // comparators not off
  logic       cmpOutsOn;                    // comparator outputs routed
  logic       refOn;                        // reference on pin 5

  // decides whether a pin's converter channel is analog;
  // higher config codes release the higher channels first
  function automatic logic isAnalog(input logic [3:0] pcfg, input int pin);
    logic [4:0] chan;
    chan = gpf_pkg::FIRST_CHANNEL + 5'(pin);
    isAnalog = ({1'b0, pcfg} <= (gpf_pkg::PCFG_ALL_ANALOG_TOP - chan));
  endfunction : isAnalog

  // read mux, shared by the bus read path
  function automatic logic [7:0] readReg(
    input logic [7:0] ofs,
    input logic [7:0] dir,
    input logic [7:0] lat,
    input logic [7:0] adc,
    input logic [7:0] cmp,
    input logic [7:0] refc,
    input logic [7:0] pins
  );
    case (ofs)
      gpf_pkg::OFS_DIR: readReg = dir;
      gpf_pkg::OFS_PIN: readReg = pins;
      gpf_pkg::OFS_LAT: readReg = lat;
      gpf_pkg::OFS_ADC: readReg = adc & gpf_pkg::ADC_WMASK;
      gpf_pkg::OFS_CMP: readReg = cmp;
      gpf_pkg::OFS_REF: readReg = refc;
      // unmapped offsets read zero
      default:          readReg = 8'h00;
    endcase
  endfunction : readReg

  // an address phase is taken when selected, ready and active
  assign accept = hsel & hready & htrans[gpf_pkg::HTRANS_ACTIVE_BIT];

  // pin synchroniser: only the second stage is read by logic
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pinMeta_q <= 8'h00;
      pinSync_q <= 8'h00;
    end
    else
    begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // comparator results come from analog logic, so resync them too
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cmpMeta_q <= 2'h0;
      cmpSync_q <= 2'h0;
    end
    else
    begin
      cmpMeta_q <= {secondComparatorResult, firstComparatorResult};
      cmpSync_q <= cmpMeta_q;
    end
  end

  // register next values: writes land at the end of the data phase
  always_comb
  begin
    fDirection_d = fDirection_q;
    fLatch_d     = fLatch_q;
    convCfg_d    = convCfg_q;
    refCtrl_d    = refCtrl_q;
    // result bits always follow the comparators
    cmpCtrl_d    = cmpCtrl_q;
    cmpCtrl_d[gpf_pkg::CMP_RES1_BIT] = cmpSync_q[0];
    cmpCtrl_d[gpf_pkg::CMP_RES2_BIT] = cmpSync_q[1];
    if (wrPend_q)
    begin
      case (wrAddr_q)
        gpf_pkg::OFS_DIR: fDirection_d = hwdata[7:0];
        // pin writes go to the latch
        gpf_pkg::OFS_PIN: fLatch_d = hwdata[7:0];
        gpf_pkg::OFS_LAT: fLatch_d = hwdata[7:0];
        gpf_pkg::OFS_ADC: convCfg_d = hwdata[7:0] & gpf_pkg::ADC_WMASK;
        gpf_pkg::OFS_CMP:
        begin
          // keep read-only result bits, store the rest
          cmpCtrl_d = (cmpCtrl_d & ~gpf_pkg::CMP_WMASK) | (hwdata[7:0] & gpf_pkg::CMP_WMASK);
        end
        gpf_pkg::OFS_REF: refCtrl_d = hwdata[7:0];
        // unmapped writes are dropped
        default: ;
      endcase
    end
  end

  // direction register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fDirection_q <= gpf_pkg::DIR_RST;
    else
      fDirection_q <= fDirection_d;
  end

  // output latch
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fLatch_q <= gpf_pkg::LAT_RST;
    else
      fLatch_q <= fLatch_d;
  end

  // analog configuration registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // config zero makes every shared pin analog
      convCfg_q <= gpf_pkg::ADC_RST;
      cmpCtrl_q <= gpf_pkg::CMP_RST;
      refCtrl_q <= gpf_pkg::REF_RST;
    end
    else
    begin
      convCfg_q <= convCfg_d;
      cmpCtrl_q <= cmpCtrl_d;
      refCtrl_q <= refCtrl_d;
    end
  end

  // data-phase tracking for writes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end
    else if (hready)
    begin
      wrPend_q <= accept & hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  // read data is fetched at the address phase from the next-state
  // values, so a read straight after a write sees the new data
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (accept & ~hwrite)
      hrdata <= {24'h00_0000, readReg(haddr[7:0], fDirection_d, fLatch_d,
                                      convCfg_d, cmpCtrl_d, refCtrl_d, pinRead)};
  end

  // zero wait states and always OKAY; hsize is not needed for word access
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // software sets mode off / config digital; hardware honours it
  assign cmpActive = (cmpCtrl_q[gpf_pkg::CMP_MODE_LSB +: 3] != gpf_pkg::CMP_MODE_OFF);
  assign cmpOutsOn = (cmpCtrl_q[gpf_pkg::CMP_MODE_LSB +: 3] == gpf_pkg::CMP_MODE_OUTS);
  // reference needs both enable and output enable
  assign refOn = refCtrl_q[gpf_pkg::REF_EN_BIT] & refCtrl_q[gpf_pkg::REF_OE_BIT];

  // per-pin logic, one copy for each pin
  for (genvar i = 0; i < PIN_COUNT; i++)
  begin : g_pin
    // pin 7 has no analog function
    if (i < gpf_pkg::ANALOG_PINS)
    begin : g_ana
      assign analogOn[i] = isAnalog(convCfg_q[gpf_pkg::PCFG_LSB +: 4], i);
    end
    else
    begin : g_dig
      assign analogOn[i] = 1'b0;
    end

    assign digInOk[i] = ~analogOn[i]
                      & ~(cmpActive & (i >= gpf_pkg::PIN_CMP_INLO) & (i <= gpf_pkg::PIN_CMP_INHI))
                      & ~(refOn & (i == gpf_pkg::PIN_REF_OUT));
    assign pinRead[i] = pinSync_q[i] & digInOk[i];

    // analog enable plays no part here
    assign oeNext[i] = ~fDirection_q[i] & ~(refOn & (i == gpf_pkg::PIN_REF_OUT));

    // second comparator result on pin 1
    if (i == gpf_pkg::PIN_CMP2_OUT)
    begin : g_c2
      assign outNext[i] = cmpOutsOn ? cmpSync_q[1] : fLatch_q[i];
    end
    // first comparator result on pin 2
    else if (i == gpf_pkg::PIN_CMP1_OUT)
    begin : g_c1
      assign outNext[i] = cmpOutsOn ? cmpSync_q[0] : fLatch_q[i];
    end
    else
    begin : g_lat
      assign outNext[i] = fLatch_q[i];
    end
  end

  // pin drivers are registered so they cannot glitch
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pinOut <= 8'h00;
      pinOe  <= 8'h00;
    end
    else
    begin
      pinOut <= outNext;
      pinOe  <= oeNext;
    end
  end

  // analog side controls
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      analogEnable <= 7'h7F;
      refOutEnable <= 1'b0;
    end
    else
    begin
      analogEnable <= analogOn[6:0];
      refOutEnable <= refOn;
    end
  end

  // select is held inactive (high) while pin 7 is an output
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      slaveSelect <= 1'b1;
    // pin 7 input feeds the select
    else if (fDirection_q[gpf_pkg::PIN_SEL_IN])
      slaveSelect <= pinSync_q[gpf_pkg::PIN_SEL_IN];
    else
      slaveSelect <= 1'b1;
  end

endmodule : gpf_port

/* File: gpf_port_sva.sv */
// concurrent checks on the port's pins and bus answers
`timescale 1ns/1ps
module gpf_port_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // pins and side controls
  input wire logic [7:0]  pinIn,
  input wire logic [7:0]  pinOut,
  input wire logic [7:0]  pinOe,
  input wire logic [6:0]  analogEnable,
  input wire logic        refOutEnable,
  input wire logic        slaveSelect
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // accepted write and read address phases
  logic wrAcc;
  logic rdAcc;
  assign wrAcc = hsel & hready & htrans[1] & hwrite;
  assign rdAcc = hsel & hready & htrans[1] & ~hwrite;
  // register-driven outputs move only two or three edges after a write
  sequence s_wr_late;
    $past(wrAcc, 2) || $past(wrAcc, 3);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erroring");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_reset_state: assert property ($fell(rst) |-> analogEnable == 7'h7F && pinOe == 8'h00)
    else $error("port not analog inputs after reset");
  a_oe_by_write: assert property ($changed(pinOe) |-> s_wr_late)
    else $error("drive enable moved without a write");
  a_out_by_write: assert property ($changed({pinOut[7:3], pinOut[0]}) |-> s_wr_late)
    else $error("pin drive moved without a write");
  a_ana_by_write: assert property ($changed({analogEnable, refOutEnable}) |-> s_wr_late)
    else $error("analog controls moved without a write");
  a_rdata_holds: assert property ($changed(hrdata) |-> $past(rdAcc))
    else $error("read data moved without a read");
  a_ref_no_drive: assert property (refOutEnable [*2] |-> !pinOe[5])
    else $error("pin five driven under reference output");
  a_sel_follows: assert property ((!pinOe[7] && $stable(pinIn[7])) [*6] |-> slaveSelect == pinIn[7])
    else $error("slave select not following pin seven");
  a_sel_idle: assert property (pinOe[7] [*2] |-> slaveSelect)
    else $error("slave select active while pin seven drives");
endmodule : gpf_port_sva
